//--- dv/nv_sram_host_asserts.sv
`timescale 1ns/10ps
module nv_sram_host_asserts
  import nv_sram_host_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire strobes_s pins,
  input wire logic [7:0] data_pins_in,
  input wire logic [7:0] data_pins_out,
  input wire logic data_pins_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_addr_steady: assert property (!pins.chip_sel_n && !pins.write_en_n |=> $stable(pins.addr))
    else $error("address moved in write");
  a_recovery_gap: assert property ($rose(pins.chip_sel_n) |-> pins.chip_sel_n [*2])
    else $error("recovery too short");
  a_no_contention: assert property (!pins.write_en_n |-> pins.out_en_n && !data_pins_oe_n)
    else $error("bus contention in write");
  a_data_setup: assert property ($rose(pins.write_en_n) |->
    !$past(data_pins_oe_n, 12) && $past(data_pins_out, 12) == data_pins_out)
    else $error("write data setup short");
  a_data_hold: assert property ($rose(pins.write_en_n) |-> !data_pins_oe_n && $stable(data_pins_out))
    else $error("write data hold short");
  a_read_wait: assert property (rsp_valid |-> !$past(pins.out_en_n, 19) && !$past(pins.chip_sel_n))
    else $error("read sampled too early");
  a_read_sample: assert property (rsp_valid |-> rsp_data == $past(data_pins_in))
    else $error("read data not bus value");
  c_read: cover property (rsp_valid);
  c_write: cover property ($rose(pins.write_en_n));
  c_clock_reg: cover property (!pins.chip_sel_n && pins.addr >= CLOCK_REG_BASE);
endmodule : nv_sram_host_asserts
bind nv_sram_host nv_sram_host_asserts i_nv_sram_host_asserts (.clock, .reset, .rsp_valid, .rsp_data,
  .pins, .data_pins_in, .data_pins_out, .data_pins_oe_n);

//--- dv/nv_sram_model.sv
`timescale 1ns/10ps
module nv_sram_model
  import nv_sram_host_pkg::*;
(
  input wire strobes_s pins,
  input wire logic [7:0] host_out,
  input wire logic host_oe_n,
  input wire logic power_fail,
  input wire logic battery_good,
  output logic [7:0] bus
);
  logic [7:0] mem [2048];
  logic [7:0] word;
  logic [7:0] junk = 8'h5a;
  logic [7:0] dev = 8'h5a;
  realtime t0 = 0;
  // backup joins only once the supply has been good at least once
  logic backup_on = 1'b0;
  always @(power_fail or pins) if (!power_fail) backup_on = 1'b1;
  // an address, select or output-enable edge restarts the access timer; write enable does not
  always @(pins.addr or pins.chip_sel_n or pins.out_en_n) t0 = $realtime;
  // clock bytes share the ram path; the flag ignores what was written
  assign word = pins.addr == DAY_REG_ADDR ? {battery_good && backup_on, mem[pins.addr][6:0]} :
    mem[pins.addr];
  // old byte for the hold time, then a moving pattern until the access time
  // steps fall on half-ns points so the bus never moves at a clock edge
  initial #0.5 forever #1 begin
    junk = ~junk + 8'h01;
    dev = $realtime - t0 >= ADDRESS_ACCESS_TIME_NS ? word : $realtime - t0 < OUTPUT_HOLD_TIME_NS ? dev : junk;
  end
  // a released bus has no pull, so it shows the pattern
  assign bus = !host_oe_n ? host_out :
    (!power_fail && !pins.chip_sel_n && !pins.out_en_n && pins.write_en_n) ? dev : junk;
  // store at the first strobe to rise while the other is still low
  always @(posedge pins.chip_sel_n or posedge pins.write_en_n)
    if (!(pins.chip_sel_n && pins.write_en_n) && !power_fail) mem[pins.addr] = host_out;
endmodule : nv_sram_model

//--- dv/tb_nv_sram_host.sv
`timescale 1ns/10ps
module tb_nv_sram_host;
  import nv_sram_host_pkg::*;
  logic clock = 0, reset = 1, req_valid = 0, power_fail = 0, battery_good = 1;
  logic req_ready, rsp_valid, battery_ok, clock_reg_access, data_pins_oe_n;
  logic [7:0] rsp_data, data_pins_in, data_pins_out, d;
  request_s req = '0;
  strobes_s pins;
  int bad_count = 0, checks = 0, cyc = 0;
  nv_sram_host i_nv_sram_host (.clock, .reset, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data,
    .battery_ok, .clock_reg_access, .pins, .data_pins_in, .data_pins_out, .data_pins_oe_n);
  nv_sram_model i_nv_sram_model (.pins, .host_out(data_pins_out), .host_oe_n(data_pins_oe_n),
    .power_fail, .battery_good, .bus(data_pins_in));
  initial forever #4 clock = ~clock;
  // a hang anywhere ends in the same report
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // inputs move 1 ns after the edge so sampling never races
  task automatic access(logic wr, logic [10:0] a, logic [7:0] v);
    while (req_ready !== 1'b1) begin @(posedge clock); #1; end
    req_valid = 1;
    req = '{wr, a, v};
    @(posedge clock);
    #1;
    req_valid = 0;
  endtask : access
  task automatic rd(logic [10:0] a);
    access(0, a, 8'h00);
    while (rsp_valid !== 1'b1) begin @(posedge clock); #1; end
    d = rsp_data;
  endtask : rd
  task automatic t_ram();
    access(1, 11'h000, 8'ha5);
    access(1, 11'h7f7, 8'h3c);
    rd(11'h000);
    chk("ram 000", 8'ha5, d);
    rd(11'h7f7);
    chk("ram 7f7", 8'h3c, d);
    chk("clock flag low", 8'h00, {7'h0, clock_reg_access});
  endtask : t_ram
  task automatic t_clock_regs();
    access(1, CLOCK_REG_BASE, 8'h19);
    rd(CLOCK_REG_BASE);
    chk("reg 7f8", 8'h19, d);
    chk("clock flag high", 8'h01, {7'h0, clock_reg_access});
  endtask : t_clock_regs
  task automatic t_battery();
    access(1, DAY_REG_ADDR, 8'h05);
    rd(DAY_REG_ADDR);
    chk("day good", 8'h85, d);
    chk("battery_ok good", 8'h01, {7'h0, battery_ok});
    battery_good = 0;
    rd(DAY_REG_ADDR);
    chk("day empty", 8'h05, d);
    chk("battery_ok", 8'h00, {7'h0, battery_ok});
    battery_good = 1;
  endtask : t_battery
  // mid-run reset: status and strobes return to their idle values at once
  task automatic t_reset();
    reset = 1;
    repeat (2) @(posedge clock);
    #1;
    reset = 0;
    chk("battery_ok reset", 8'h01, {7'h0, battery_ok});
    chk("strobes idle", 8'h07, {5'h0, pins.chip_sel_n, pins.out_en_n, pins.write_en_n});
    chk("bus released", 8'h01, {7'h0, data_pins_oe_n});
  endtask : t_reset
  task automatic t_power_fail();
    power_fail = 1;
    access(1, 11'h000, 8'h5a);
    rd(11'h000);
    power_fail = 0;
    rd(11'h000);
    chk("blocked write", 8'ha5, d);
  endtask : t_power_fail
  initial begin
    repeat (20) @(posedge clock);
    #1;
    reset = 0;
    t_ram();
    t_clock_regs();
    t_battery();
    t_reset();
    t_power_fail();
    report_and_stop();
  end
endmodule : tb_nv_sram_host

//--- rtl/nv_sram_host.sv
`timescale 1ns/10ps
// Functional notes
// RL1 - read happens when select low, output enable low, write enable high
// RL2 - reads ripple through; any address change starts a new access
// RL3 - data valid after address, select and output-enable access times
// RL4 - device drives data pins only while selected and output enabled
// RL5 - early enabled outputs show undefined data until access time met
// RL6 - address change keeps old data briefly, then indeterminate until access done
// RL7 - write mode when write enable and select low; starts at later fall
// RL8 - host holds address stable for the whole write cycle
// RL9 - host keeps select or write enable inactive for recovery time between cycles
// RL10 - host sets write data up before write end and holds it after
// RL11 - host keeps output enable high during writes to avoid contention
// RL12 - with output enable low first, device floats bus after write enable falls
// RL13 - power-fail blocks every read and write to clock and memory
// RL14 - battery backup connects only after first supply rise above threshold
// RL15 - battery ok flag is bit 7 of day register, read-only, 1 when good
// RL16 - clock registers occupy the top eight byte addresses
// RL17 - device stores byte at first rising edge of select or write enable
module nv_sram_host
  import nv_sram_host_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DATA_W = DATA_WIDTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire request_s req,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic battery_ok,
  output logic clock_reg_access,
  output strobes_s pins,
  input wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0] data_pins_out,
  output logic data_pins_oe_n
);

  // sequencer and pin drive
  state_e state_reg, state_next;
  logic [CYCLE_COUNT_WIDTH-1:0] count_reg, count_next;
  strobes_s pins_reg, pins_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic drive_reg, drive_next;

  // read capture
  logic sample_now;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic rsp_reg, rsp_next;

  // status kept between transfers
  logic batt_reg, batt_next;
  logic was_day_reg, was_day_next;
  logic top_reg, top_next;

  // sequencer: one transfer at a time, strobes paced by cycle counts
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    pins_next = pins_reg;
    wdata_next = wdata_reg;
    drive_next = drive_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          pins_next.addr = req.addr;
          pins_next.chip_sel_n = 1'b0;
          if (req.write) begin
            // output enable stays high so the bus never fights the device
            pins_next.out_en_n = 1'b1; // RL11
            wdata_next = req.wdata;
            drive_next = 1'b1;
            pins_next.write_en_n = 1'b0; // RL7
            count_next = CYCLE_COUNT_WIDTH'(WRITE_PULSE_CYCLES);
            state_next = ST_WRITE;
          end else begin
            pins_next.out_en_n = 1'b0; // RL1
            count_next = CYCLE_COUNT_WIDTH'(READ_WAIT_CYCLES);
            state_next = ST_READ;
          end
        end
      end
      ST_READ: begin
        // wait out the slowest access time; earlier samples may be undefined
        if (count_reg > 1) begin
          count_next = count_reg - 1'b1; // RL3 RL5
        end else begin
          // the capture group takes the bus on this same edge
          pins_next.out_en_n = 1'b1;
          pins_next.chip_sel_n = 1'b1; // RL4
          count_next = CYCLE_COUNT_WIDTH'(FLOAT_CYCLES);
          state_next = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        // device may still drive for its data-off time; hold bus released
        if (count_reg > 1) begin
          count_next = count_reg - 1'b1;
        end else begin
          count_next = CYCLE_COUNT_WIDTH'(RECOVERY_CYCLES);
          state_next = ST_RECOVER;
        end
      end
      ST_WRITE: begin
        // pulse covers both width and data setup before the rising edge
        if (count_reg > 1) begin
          count_next = count_reg - 1'b1; // RL10
        end else begin
          pins_next.write_en_n = 1'b1; // RL17
          count_next = CYCLE_COUNT_WIDTH'(HOLD_CYCLES);
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // address and data kept through the hold after write end
        if (count_reg > 1) begin
          count_next = count_reg - 1'b1; // RL8
        end else begin
          pins_next.chip_sel_n = 1'b1;
          drive_next = 1'b0;
          count_next = CYCLE_COUNT_WIDTH'(RECOVERY_CYCLES);
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // strobes stay high for the recovery gap before the next take
        if (count_reg > 1) begin
          count_next = count_reg - 1'b1; // RL9
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        // an unknown code parks the bus released and returns to idle
        state_next = ST_IDLE;
        pins_next = '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1, addr: '0};
        drive_next = 1'b0;
      end
    endcase
  end

  // registers only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
      pins_reg <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1, addr: '0};
      wdata_reg <= '0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      pins_reg <= pins_next;
      wdata_reg <= wdata_next;
      drive_reg <= drive_next;
    end
  end

  // the last wait cycle of a read; the slowest access time has passed by then
  assign sample_now = (state_reg == ST_READ) && (count_reg < CYCLE_COUNT_WIDTH'(2));

  // read capture: an earlier sample could still hold the undefined interval
  always_comb begin
    rdata_next = rdata_reg;
    rsp_next = 1'b0;
    if (sample_now) begin
      rdata_next = data_pins_in; // RL3 RL5
      rsp_next = 1'b1;
    end
  end

  // capture registers; the response is a one-cycle pulse
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
      rsp_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rsp_reg <= rsp_next;
    end
  end

  // status: address class is latched at the take, the flag only on day reads,
  // so a plain ram read never disturbs the last battery report
  always_comb begin
    batt_next = batt_reg;
    was_day_next = was_day_reg;
    top_next = top_reg;
    if (req_valid && req_ready) begin
      top_next = (req.addr >= CLOCK_REG_BASE); // RL16
      was_day_next = (req.addr == DAY_REG_ADDR);
    end
    if (sample_now && was_day_reg) begin
      batt_next = data_pins_in[BATTERY_OK_BIT]; // RL15
    end
  end

  // status registers; the battery reads good until a day read says otherwise
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      batt_reg <= 1'b1;
      was_day_reg <= 1'b0;
      top_reg <= 1'b0;
    end else begin
      batt_reg <= batt_next;
      was_day_reg <= was_day_next;
      top_reg <= top_next;
    end
  end

  // handshake is combinational; data and pins come from flops
  assign req_ready = (state_reg == ST_IDLE);
  assign rsp_valid = rsp_reg;
  assign rsp_data = rdata_reg;
  assign battery_ok = batt_reg;
  assign clock_reg_access = top_reg;
  assign pins = pins_reg;
  assign data_pins_out = wdata_reg;
  assign data_pins_oe_n = ~drive_reg; // low while host drives
endmodule : nv_sram_host

//--- rtl/nv_sram_host_pkg.sv
package nv_sram_host_pkg;
  // clock and array geometry
  localparam int CLOCK_MHZ = 125;
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int ADDR_WIDTH = 11;
  localparam int DATA_WIDTH = 8;
  // top eight locations hold clock and control bytes
  localparam logic [10:0] CLOCK_REG_BASE = 11'h7f8;
  localparam logic [10:0] DAY_REG_ADDR = 11'h7fc;
  localparam int BATTERY_OK_BIT = 7;
  // device timing for the slowest grade, in ns
  localparam int ADDRESS_ACCESS_TIME_NS = 150;
  localparam int SELECT_ACCESS_TIME_NS = 150;
  localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 130;
  localparam int OUTPUT_HOLD_TIME_NS = 5;
  localparam int WRITE_PULSE_TIME_NS = 140;
  localparam int DATA_SETUP_TIME_NS = 90;
  localparam int DATA_HOLD_TIME_NS = 0;
  localparam int WRITE_RECOVERY_TIME_NS = 10;
  localparam int WRITE_TO_FLOAT_TIME_NS = 50;
  localparam int DATA_OFF_TIME_NS = 50;
  // least times round up to whole cycles, never under one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles
  localparam int READ_WAIT_CYCLES = ns_to_cycles(ADDRESS_ACCESS_TIME_NS) + 1;
  localparam int WRITE_PULSE_CYCLES = ns_to_cycles(WRITE_PULSE_TIME_NS);
  localparam int SETUP_CYCLES = ns_to_cycles(DATA_SETUP_TIME_NS);
  localparam int HOLD_CYCLES = ns_to_cycles(DATA_HOLD_TIME_NS);
  localparam int RECOVERY_CYCLES = ns_to_cycles(WRITE_RECOVERY_TIME_NS);
  localparam int FLOAT_CYCLES = ns_to_cycles(DATA_OFF_TIME_NS);
  localparam int CYCLE_COUNT_WIDTH = 6;

  typedef struct packed {
    logic write;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
  } request_s;

  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic write_en_n;
    logic [ADDR_WIDTH-1:0] addr;
  } strobes_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_FLOAT = 3'b010,
    ST_WRITE = 3'b011,
    ST_HOLD = 3'b100,
    ST_RECOVER = 3'b101
  } state_e;
endpackage : nv_sram_host_pkg
